// [core/spcf_ctrl.sv]
// Serial port control register with port enable pin routing and error flags.
// Assumes the shift datapath reports buffer writes, byte completion and busy on aclk;
// serial pins arrive asynchronous and are synchronised here.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module spcf_ctrl (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Datapath events
  input  wire spcf_pkg::spcf_events_type dp_events,
  input  wire logic                    buf_read,
  output logic                         byte_discard,
  output logic                         port_enabled,
  output logic [3:0]                   mode_select,
  output logic                         clock_polarity,
  // Serial function side and general I/O side
  input  wire spcf_pkg::spcf_pins_type port_out,
  input  wire spcf_pkg::spcf_pins_type gpio_out,
  input  wire spcf_pkg::spcf_pins_type gpio_oe,
  output spcf_pkg::spcf_pins_type      pin_out,
  output spcf_pkg::spcf_pins_type      pin_oe,
  input  wire spcf_pkg::spcf_pins_type pin_in,
  output spcf_pkg::spcf_pins_type      port_in,
  output logic                         sck_rise,
  output logic                         irq
);
  import spcf_pkg::*;

  // ==========================================================================
  // State; every register has its next value beside it
  logic [7:0]                 ctrl_reg;
  logic [7:0]                 ctrl_next;
  logic                       full_reg;
  logic                       full_next;
  logic [SPCF_NUM_EVENTS-1:0] stat_reg;
  logic [SPCF_NUM_EVENTS-1:0] stat_next;
  logic [SPCF_NUM_EVENTS-1:0] mask_reg;
  logic [SPCF_NUM_EVENTS-1:0] mask_next;
  logic                       sck_prev_reg;
  logic                       sck_prev_next;
  logic                       aw_hold_reg;
  logic                       aw_hold_next;
  logic                       w_hold_reg;
  logic                       w_hold_next;
  logic [7:0]                 awaddr_reg;
  logic [7:0]                 awaddr_next;
  logic [31:0]                wdata_reg;
  logic [31:0]                wdata_next;
  logic [3:0]                 wstrb_reg;
  logic [3:0]                 wstrb_next;
  logic                       bvalid_reg;
  logic                       bvalid_next;
  logic [1:0]                 bresp_reg;
  logic [1:0]                 bresp_next;
  logic                       rvalid_reg;
  logic                       rvalid_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic [1:0]                 rresp_reg;
  logic [1:0]                 rresp_next;

  // Combinational helpers
  logic [3:0]                 pins_sync;
  logic                       is_i2c;
  logic                       is_slave;
  logic                       aw_take;
  logic                       w_take;
  logic                       do_write;
  logic                       collision;
  logic                       overflow;

  // ==========================================================================
  // Pin synchronisers; the port sees only synchronised levels
  spcf_sync #(.WIDTH(4)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pin_in),
    .sync_out (pins_sync)
  );

  // Mode decode: codes from six up are I2C, four and five SPI slave, the rest SPI master
  assign is_i2c   = (ctrl_reg[3:0] >= SPCF_MODE_I2C_LO);
  assign is_slave = !is_i2c && (ctrl_reg[3:0] >= SPCF_MODE_SLAVE_LO);

  // ==========================================================================
  // Pin routing: enable hands pins to the port, otherwise back to general I/O.
  // Directions stay under the general I/O enables either way, since enabling
  // the port does not set them.
  always_comb begin
    port_in = pins_sync;
    pin_oe  = gpio_oe;
    if (ctrl_reg[SPCF_BIT_EN]) begin
      pin_out = port_out;
    end else begin
      pin_out = gpio_out;
    end
  end

  // Link clock edge from the synchronised serial clock
  assign sck_prev_next = port_in.sck;
  assign sck_rise      = port_in.sck && !sck_prev_reg;

  // ==========================================================================
  // Flag events. A buffer write while busy cannot start a transfer.
  // Both events are ignored while the port is off, so stale datapath pulses set nothing.
  assign collision = ctrl_reg[SPCF_BIT_EN] && dp_events.buf_write && dp_events.busy;
  // Master SPI never overflows: each transfer is started by a buffer write.
  assign overflow  = ctrl_reg[SPCF_BIT_EN] && dp_events.byte_done && full_reg
                     && (is_slave || is_i2c);
  assign byte_discard = overflow;

  // Receive buffer occupancy, cleared by a read of the buffer.
  // A read and a new byte in one cycle still count as overflow: the buffer was
  // full when the byte landed.
  always_comb begin
    full_next = full_reg;
    if (buf_read) full_next = 1'b0;
    if (dp_events.byte_done && !overflow) full_next = 1'b1;
    if (!ctrl_reg[SPCF_BIT_EN]) full_next = 1'b0;
  end

  // ==========================================================================
  // AXI write path: address and data taken in either order, response after both
  // Writes to the read-only pin view or with the low byte lane off change nothing
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  // Write fires once both halves are in hand, counting one taken at this very
  // edge; built from the handshakes alone so that the holding logic below has
  // no loop through it
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign do_write      = (aw_hold_reg || aw_take) && (w_hold_reg || w_take) && !bvalid_reg;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (awaddr_next == SPCF_ADDR_CONTROL || awaddr_next == SPCF_ADDR_STATUS ||
                      awaddr_next == SPCF_ADDR_MASK || awaddr_next == SPCF_ADDR_PINS)
                     ? SPCF_RESP_OKAY : SPCF_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // ==========================================================================
  // Registers written by software; hardware sets win over software clears
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (do_write && wstrb_next[0]) begin
      unique case (awaddr_next)
        SPCF_ADDR_CONTROL: ctrl_next = wdata_next[7:0];   // Flags clear only by software
        SPCF_ADDR_STATUS:  stat_next = stat_reg & ~wdata_next[SPCF_NUM_EVENTS-1:0];
        SPCF_ADDR_MASK:    mask_next = wdata_next[SPCF_NUM_EVENTS-1:0];
        default: ;
      endcase
    end
    if (collision) begin
      ctrl_next[SPCF_BIT_COLLISION] = 1'b1;
      stat_next[0]             = 1'b1;
    end
    if (overflow) begin
      ctrl_next[SPCF_BIT_ROV] = 1'b1;
      stat_next[1]            = 1'b1;
    end
    // Byte complete is reported in every mode, even when the byte is dropped
    if (ctrl_reg[SPCF_BIT_EN] && dp_events.byte_done) stat_next[2] = 1'b1;
  end

  // Level interrupt: stays high until software clears the status bit or masks it
  assign irq = |(stat_reg & mask_reg);

  // ==========================================================================
  // AXI read path, one word per read
  // A new address is refused while the previous answer waits, so rdata cannot change under it
  assign s_axi_arready = !rvalid_reg;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = SPCF_RESP_OKAY;
      unique case (s_axi_araddr)
        SPCF_ADDR_CONTROL: rdata_next = {24'h000000, ctrl_reg};
        SPCF_ADDR_STATUS:  rdata_next = {29'h00000000, stat_reg};
        SPCF_ADDR_MASK:    rdata_next = {29'h00000000, mask_reg};
        SPCF_ADDR_PINS:    rdata_next = {27'h0000000, full_reg, port_in};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = SPCF_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ==========================================================================
  // Register stages, one per group of state
  // Software registers; reset leaves the port off and both flags clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= SPCF_CONTROL_RST;
      stat_reg <= SPCF_IRQ_RST;
      mask_reg <= SPCF_IRQ_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  // Receive occupancy and link clock history; the history resets to the idle
  // low level of the clock pin so that no false edge follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_reg     <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      full_reg     <= full_next;
      sck_prev_reg <= sck_prev_next;
    end
  end

  // Write channel holding registers and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SPCF_RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= SPCF_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;
  assign port_enabled   = ctrl_reg[SPCF_BIT_EN];
  assign mode_select    = ctrl_reg[3:0];
  assign clock_polarity = ctrl_reg[SPCF_BIT_POLARITY];

endmodule : spcf_ctrl

// [core/spcf_pkg.sv]
// Constants, register map and carrier types of the serial port control flags block.
// Assumes a 32-bit AXI4-Lite register bus and one core clock domain.
// Notes on behaviour
// - SPI enabled: clock, data out, data in, slave select pins come from the port.
// - Port enable clear: port off, every pin back to general-purpose I/O.
// - I2C enabled: port becomes the source of the data and clock pins.
// - SPI: byte completes with buffer unread sets overflow; new byte is dropped.
// - SPI master never sets overflow; only software clears the overflow flag.
// - I2C: byte arrives with previous unread sets overflow; meaningless when transmitting.
package spcf_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] SPCF_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] SPCF_ADDR_STATUS  = 8'h04;
  localparam logic [7:0] SPCF_ADDR_MASK    = 8'h08;
  localparam logic [7:0] SPCF_ADDR_PINS    = 8'h0c;

  // ==========================================================================
  // Control register fields
  localparam int          SPCF_BIT_COLLISION = 7;
  localparam int          SPCF_BIT_ROV    = 6;
  localparam int          SPCF_BIT_EN     = 5;
  localparam int          SPCF_BIT_POLARITY  = 4;
  localparam logic [7:0]  SPCF_CONTROL_RST = 8'h00;
  localparam logic [3:0]  SPCF_MODE_I2C_LO = 4'h6;
  localparam logic [3:0]  SPCF_MODE_SLAVE_LO = 4'h4;

  // Interrupt status bits: 0 collision, 1 overflow, 2 byte complete
  localparam int          SPCF_NUM_EVENTS  = 3;
  localparam logic [2:0]  SPCF_IRQ_RST     = 3'h0;

  // AXI responses
  localparam logic [1:0]  SPCF_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SPCF_RESP_SLVERR = 2'h2;

  // Pin synchroniser stage count
  localparam int          SPCF_SYNC_STAGES = 2;

  typedef struct packed {
    logic sck;
    logic sdo;
    logic sdi;
    logic ss;
  } spcf_pins_type;

  typedef struct packed {
    logic byte_done;
    logic buf_write;
    logic busy;
  } spcf_events_type;

endpackage : spcf_pkg

// [core/spcf_sync.sv]
// Two-stage synchroniser vector for inputs from outside the core clock domain.
// Assumes a synchronous active-low reset.
`timescale 1ns/1ps
module spcf_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import spcf_pkg::*;

  // ==========================================================================
  // Stage registers
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Elaboration check: a zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_width_check
    $error("spcf_sync: WIDTH must be at least 1");
  end

  // First stage is read only by the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : spcf_sync

// [test/serial_port_ctrl_flags_test.sv]
// Self-checking bench for the control flags block over AXI4-Lite.
// Assumes the checker is bound by its own file and the peer drives the pins.
`timescale 1ns/1ps
module serial_port_ctrl_flags_test;
  import spcf_pkg::*;
  logic            aclk = 1'b0, aresetn = 1'b0, start = 1'b0, buf_read = 1'b0;
  logic [7:0]      s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]      s_axi_wstrb = 4'hf, mode_select;
  logic [1:0]      s_axi_bresp, s_axi_rresp, rs;
  logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic            s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic            byte_discard, port_enabled, clock_polarity, sck_rise, irq, disc;
  spcf_events_type dp_events = '0;
  spcf_pins_type   port_out = 4'ha, gpio_out = 4'h5, gpio_oe = 4'h3, pin_out, pin_oe, pin_in, port_in;
  int              n_errors = 0, checks = 0;

  spcf_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dp_events, .buf_read, .byte_discard,
    .port_enabled, .mode_select, .clock_polarity, .port_out, .gpio_out, .gpio_oe, .pin_out, .pin_oe, .pin_in,
    .port_in, .sck_rise, .irq);
  spcf_peer u_peer (.tx_byte(8'ha5), .start, .pins(pin_in));

  // ==========================================================================
  // Clock, report and bus tasks
  always #2 aclk = ~aclk;

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write waits on bvalid; a full wait counts as a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 64 && !s_axi_bvalid; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 64) chk("write wait", 1, 0);
    if (i == 64) stop_test();
    @(posedge aclk);
  endtask : wr

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    int i;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 64 && !s_axi_rvalid; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 64) chk("read wait", 1, 0);
    if (i == 64) stop_test();
    @(posedge aclk);
    chk(what, exp, rd);
  endtask : rc

  // One datapath pulse; discard is sampled inside the pulse cycle
  task automatic ev(input logic is_byte);
    if (is_byte) dp_events.byte_done <= 1'b1;
    else dp_events.buf_write <= 1'b1;
    #1 disc = byte_discard;
    @(posedge aclk);
    dp_events.byte_done <= 1'b0;
    dp_events.buf_write <= 1'b0;
    @(posedge aclk);
  endtask : ev

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rc("control", 8'h00, 32'h0);
    rc("status", 8'h04, 32'h0);
    chk("irq", 0, irq);
    chk("enabled", 0, port_enabled);
    chk("polarity", 0, clock_polarity);
    chk("mode", 0, mode_select);
    rc("unmapped", 8'h10, 32'h0);
    chk("rresp", 2'h2, rs);
    wr(8'h10, 32'hff);
    chk("bresp", 2'h2, rs);
  endtask : t_reset

  task automatic t_enable();
    wr(8'h00, 32'h30);
    chk("pin_out", port_out, pin_out);
    chk("enabled", 1, port_enabled);
    chk("polarity", 1, clock_polarity);
    chk("pin_oe", gpio_oe, pin_oe);
    wr(8'h00, 32'h00);
    chk("pin_out", gpio_out, pin_out);
    wr(8'h00, 32'h26);
    chk("pin_out", port_out, pin_out);
  endtask : t_enable

  // Collision: idle write, busy write, then disabled busy write is ignored
  task automatic t_collision();
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h01);
    ev(0);
    rc("control", 8'h00, 32'h20);
    dp_events.busy <= 1'b1;
    ev(0);
    rc("control", 8'h00, 32'ha0);
    chk("irq", 1, irq);
    wr(8'h04, 32'h01);
    chk("irq", 0, irq);
    rc("control", 8'h00, 32'ha0);
    wr(8'h00, 32'h00);
    ev(0);
    rc("control", 8'h00, 32'h00);
    dp_events.busy <= 1'b0;
  endtask : t_collision

  // Two bytes in a row, optionally read between them
  task automatic t_overflow(input logic [3:0] mode, input logic read_mid, input logic ov);
    wr(8'h08, 32'h02);
    wr(8'h00, {26'h0, 2'h2, mode} >> 0 | 32'h20);
    ev(1);
    buf_read <= read_mid;
    @(posedge aclk);
    buf_read <= 1'b0;
    ev(1);
    chk("discard", ov, disc);
    rc("control", 8'h00, {24'h0, 1'b0, ov, 2'h2, mode});
    chk("irq", ov, irq);
    chk("mode", mode, mode_select);
    wr(8'h00, 32'h00);
    wr(8'h04, 32'h07);
  endtask : t_overflow

  task automatic t_link();
    int n;
    n = 0;
    wr(8'h00, 32'h24);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    repeat (400) @(posedge aclk) n += sck_rise;
    chk("sck rises", 8, n);
    chk("ss idle", 1, port_in.ss);
    wr(8'h00, 32'h00);
  endtask : t_link

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_enable();
    t_collision();
    t_overflow(4'h0, 0, 0);
    t_overflow(4'h4, 0, 1);
    t_overflow(4'h5, 1, 0);
    t_overflow(4'h6, 0, 1);
    t_overflow(4'hf, 0, 1);
    t_link();
    stop_test();
  end
endmodule : serial_port_ctrl_flags_test

// [test/spcf_chk.sv]
// Assertion checker for the control flags block, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module spcf_chk (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire spcf_pkg::spcf_events_type dp_events,
  input wire logic                    byte_discard,
  input wire logic                    port_enabled,
  input wire logic [3:0]              mode_select,
  input wire spcf_pkg::spcf_pins_type port_out,
  input wire spcf_pkg::spcf_pins_type gpio_out,
  input wire spcf_pkg::spcf_pins_type gpio_oe,
  input wire spcf_pkg::spcf_pins_type pin_out,
  input wire spcf_pkg::spcf_pins_type pin_oe,
  input wire spcf_pkg::spcf_pins_type pin_in,
  input wire spcf_pkg::spcf_pins_type port_in
);
  import spcf_pkg::*;
  // ==========================================================================
  // Pin routing, flags and bus answers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  pin_mux_a: assert property (pin_out == (port_enabled ? port_out : gpio_out))
    else $error("pin source wrong");
  pin_dir_a: assert property (pin_oe == gpio_oe)
    else $error("pin direction changed by port");
  off_no_discard_a: assert property (!port_enabled |-> !byte_discard)
    else $error("discard while disabled");
  master_no_ov_a: assert property (mode_select < 4'h4 |-> !byte_discard)
    else $error("overflow in master mode");
  discard_cause_a: assert property (byte_discard |-> dp_events.byte_done)
    else $error("discard without byte");
  // Data in follows the pin two cycles later, whether or not the port is enabled
  in_lat_a: assert property ($past(aresetn, 2) && $past(aresetn) |-> port_in == $past(pin_in, 2))
    else $error("pin input latency wrong");
  reset_off_a: assert property (!$past(aresetn) |-> !port_enabled && mode_select == 4'h0)
    else $error("control not clear after reset");
  b_follow_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_follow_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : spcf_chk

bind spcf_ctrl spcf_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .dp_events,
  .byte_discard, .port_enabled, .mode_select, .port_out, .gpio_out, .gpio_oe, .pin_out, .pin_oe, .pin_in, .port_in);

// [test/spcf_peer.sv]
// Far-side SPI peripheral model: sends one byte per start pulse.
// Assumes a 160 ns link clock that stands still outside frames.
`timescale 1ns/1ps
module spcf_peer (
  input  wire logic [7:0]         tx_byte,
  input  wire logic               start,
  output spcf_pkg::spcf_pins_type pins
);
  import spcf_pkg::*;
  // ==========================================================================
  // Frame generator; released lines flip so no stale value looks valid
  initial pins = 4'h3;
  always @(posedge start) begin
    #1 pins.ss = 1'b0; // Off the core clock edge, so no pin change races the sampling flops
    for (int i = 7; i >= 0; i--) begin
      pins.sdi = tx_byte[i]; // Most significant bit first
      #80 pins.sck = 1'b1;
      #80 pins.sck = 1'b0;
    end
    pins.ss = 1'b1;
    pins.sdi = ~pins.sdi;
    pins.sdo = ~pins.sdo;
  end
endmodule : spcf_peer
